/* File: quad_pot_regs.vh */
// Constants for the quad potentiometer command engine
`ifndef QUAD_POT_REGS_VH
`define QUAD_POT_REGS_VH

// ----------------------------------------------------------------
// Memory map (command_address_field values)
// ----------------------------------------------------------------
`define QP_ADDR_WIPER0 4'h0
`define QP_ADDR_WIPER1 4'h1
`define QP_ADDR_TCON0 4'h4
`define QP_ADDR_STATUS 4'h5
`define QP_ADDR_WIPER2 4'h6
`define QP_ADDR_WIPER3 4'h7
`define QP_ADDR_TCON1 4'ha
`define QP_MEM_DEPTH 16

// ----------------------------------------------------------------
// Command byte layout and command_opcode_field encodings
// ----------------------------------------------------------------
`define QP_CMD_ADDR_MSB 7
`define QP_CMD_ADDR_LSB 4
`define QP_CMD_OP_MSB 3
`define QP_CMD_OP_LSB 2
`define QP_CMD_TOP_BIT 0
`define QP_OP_WRITE 2'h0
`define QP_OP_INC 2'h1
`define QP_OP_DEC 2'h2
`define QP_OP_READ 2'h3

// ----------------------------------------------------------------
// Wiper ranges, reset values and byte bit counts
// ----------------------------------------------------------------
`define QP_FULL_8BIT 9'h100
`define QP_FULL_7BIT 9'h080
`define QP_MID_8BIT 9'h080
`define QP_MID_7BIT 9'h040
`define QP_TCON_RESET 9'h1ff
`define QP_BITS_PER_BYTE 4'h8
`define QP_LAST_TX_BIT 4'h7

`endif

/* File: quad_pot_i2c_command_engine.v */
// I2C slave command engine of a quad volatile digital potentiometer
`timescale 1ns/100ps
// Functional notes
// - Write is control byte, ack, command byte, ack, data byte, ack, then Stop/Restart.
// - Volatile data is committed during the acknowledge after each full byte.
// - Stop or Restart inside a data byte discards it; location unchanged.
// - One control byte allows many command/data pairs to any volatile address.
// - High voltage on address pin zero flags the command sequence as high-voltage.
// - Read: write control, command, restart, read control, high byte, ack, low byte.
// - Reads use the last valid command address; pointer resets to 00h.
// - Address pointer survives Stop and Repeated Start.
// - Device keeps sending while master acknowledges; master ends with a nack.
// - On master nack the device releases the data line.
// - Undefined command: data line released, bus ignored until Start and control byte.
// - Increment valid only at wiper addresses 00h, 01h, 06h, 07h.
// - Increment adds one, saturating at 100h or 80h by resolution.
// - Increment leaves full-scale or reserved values unchanged.
// - Wiper takes its incremented value right after the command acknowledge.
// - Any valid command may follow an increment without a Stop.
// - Invalid address/opcode pair is not acknowledged; commands ignored until Start.
// - Write value is command top bit joined above the eight data bits.
`include "quad_pot_regs.vh"

module quad_pot_i2c_command_engine #(
  parameter EIGHT_BIT = 1,
  // Upper five slave address bits; value is arbitrary
  parameter [4:0] SLAVE_ADDR_HI = 5'h0a
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire brownout_reset_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire slave_address_pin_zero_i,
  input wire slave_address_pin_one_i,
  input wire high_voltage_command_flag_i,
  output reg high_voltage_command_flag_o,
  output wire [35:0] wiper_o,
  output wire [17:0] tcon_o
);

  // ----------------------------------------------------------------
  // States and byte phases
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_TX = 3'h3;
  localparam [2:0] ST_MACK = 3'h4;
  localparam [2:0] ST_IGN = 3'h5;
  localparam [1:0] PH_CTRL = 2'h0;
  localparam [1:0] PH_CMD = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  // Resolution picks the ceiling and the reset mid-scale
  localparam [8:0] FULL = EIGHT_BIT ? `QP_FULL_8BIT : `QP_FULL_7BIT;
  localparam [8:0] MID = EIGHT_BIT ? `QP_MID_8BIT : `QP_MID_7BIT;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Legal address/opcode pairs; decrement is not built here
  function cmd_ok;
    input [3:0] adr;
    input [1:0] op;
    reg wiper;
    reg vol;
    begin
      wiper = (adr == `QP_ADDR_WIPER0) || (adr == `QP_ADDR_WIPER1) ||
              (adr == `QP_ADDR_WIPER2) || (adr == `QP_ADDR_WIPER3);
      vol = wiper || (adr == `QP_ADDR_TCON0) || (adr == `QP_ADDR_TCON1);
      case (op)
        `QP_OP_WRITE: cmd_ok = vol;
        `QP_OP_INC: cmd_ok = wiper;
        `QP_OP_READ: cmd_ok = vol || (adr == `QP_ADDR_STATUS);
        default: cmd_ok = 1'b0;
      endcase
    end
  endfunction

  // High byte carries only data bit 8; the seven bits above it read zero
  function [7:0] rd_byte;
    input [8:0] val;
    input lo;
    begin
      rd_byte = lo ? val[7:0] : {7'h00, val[8]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg scl_s1_q, scl_s2_q, scl_d3_q;
  reg sda_s1_q, sda_s2_q, sda_d3_q;
  reg hv_s1_q, hv_s2_q;
  reg bor_s1_q, bor_s2_q;
  reg [1:0] pin_s1_q, pin_s2_q;

  // Pins come from another domain, so two flops before any use
  always @(posedge sys_clk_i) begin
    scl_s1_q <= scl_i;
    scl_s2_q <= scl_s1_q;
    scl_d3_q <= scl_s2_q;
    sda_s1_q <= sda_i;
    sda_s2_q <= sda_s1_q;
    sda_d3_q <= sda_s2_q;
    hv_s1_q <= high_voltage_command_flag_i;
    hv_s2_q <= hv_s1_q;
    bor_s1_q <= brownout_reset_i;
    bor_s2_q <= bor_s1_q;
    pin_s1_q <= {slave_address_pin_one_i, slave_address_pin_zero_i};
    pin_s2_q <= pin_s1_q;
  end

  // Bus events, seen only on the second and third stage
  wire scl_rise = scl_s2_q & ~scl_d3_q;
  wire scl_fall = ~scl_s2_q & scl_d3_q;
  wire start_det = scl_s2_q & scl_d3_q & sda_d3_q & ~sda_s2_q;
  wire stop_det = scl_s2_q & scl_d3_q & ~sda_d3_q & sda_s2_q;
  // Brown-out clears the same state as a power-on reset
  wire rst_all = rst_i | bor_s2_q;

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  reg [2:0] state_q;
  reg [2:0] nxt_q;
  reg [1:0] phase_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [3:0] ptr_q;
  reg top_q;
  reg inc_q;
  reg lo_q;
  reg mack_q;
  reg [8:0] mem_q [0:`QP_MEM_DEPTH-1];
  wire [3:0] cmd_adr = sh_q[`QP_CMD_ADDR_MSB:`QP_CMD_ADDR_LSB];
  wire [1:0] cmd_op = sh_q[`QP_CMD_OP_MSB:`QP_CMD_OP_LSB];
  wire [8:0] cur_val = mem_q[ptr_q];
  wire [7:0] next_byte = rd_byte(cur_val, ~lo_q);
  integer i;

  // Byte engine: receive, acknowledge, transmit, watch master ack
  always @(posedge sys_clk_i) begin
    sda_o <= 1'b0;
    if (rst_all) begin
      state_q <= ST_IDLE;
      nxt_q <= ST_RX;
      phase_q <= PH_CTRL;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= `QP_ADDR_WIPER0;
      top_q <= 1'b0;
      inc_q <= 1'b0;
      lo_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_o <= 1'b0;
      high_voltage_command_flag_o <= 1'b0;
      for (i = 0; i < `QP_MEM_DEPTH; i = i + 1) begin
        mem_q[i] <= 9'h000;
      end
      mem_q[`QP_ADDR_WIPER0] <= MID;
      mem_q[`QP_ADDR_WIPER1] <= MID;
      mem_q[`QP_ADDR_WIPER2] <= MID;
      mem_q[`QP_ADDR_WIPER3] <= MID;
      mem_q[`QP_ADDR_TCON0] <= `QP_TCON_RESET;
      mem_q[`QP_ADDR_TCON1] <= `QP_TCON_RESET;
    end else if (start_det) begin
      // A Start aborts anything; half-received bytes are dropped
      state_q <= ST_RX;
      phase_q <= PH_CTRL;
      cnt_q <= 4'h0;
      inc_q <= 1'b0;
      sda_oe_o <= 1'b0;
      high_voltage_command_flag_o <= hv_s2_q;
    end else if (stop_det) begin
      // Pointer is left alone across Stop
      state_q <= ST_IDLE;
      inc_q <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `QP_BITS_PER_BYTE) begin
            cnt_q <= 4'h0;
            case (phase_q)
              PH_CTRL: begin
                if (sh_q[7:1] == {SLAVE_ADDR_HI, pin_s2_q}) begin
                  sda_oe_o <= 1'b1;
                  state_q <= ST_ACK;
                  phase_q <= PH_CMD;
                  lo_q <= 1'b0;
                  nxt_q <= sh_q[0] ? ST_TX : ST_RX;
                end else begin
                  state_q <= ST_IGN;
                end
              end
              PH_CMD: begin
                if (cmd_ok(cmd_adr, cmd_op)) begin
                  sda_oe_o <= 1'b1;
                  state_q <= ST_ACK;
                  nxt_q <= ST_RX;
                  ptr_q <= cmd_adr;
                  top_q <= sh_q[`QP_CMD_TOP_BIT];
                  inc_q <= (cmd_op == `QP_OP_INC);
                  // Increment and read stay in command phase
                  phase_q <= (cmd_op == `QP_OP_WRITE) ? PH_DATA : PH_CMD;
                end else begin
                  // Line stays released: that is the nack
                  state_q <= ST_IGN;
                end
              end
              default: begin
                // Data is committed as the acknowledge starts
                mem_q[ptr_q] <= {top_q, sh_q};
                sda_oe_o <= 1'b1;
                state_q <= ST_ACK;
                nxt_q <= ST_RX;
                phase_q <= PH_CMD;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            inc_q <= 1'b0;
            // Saturate at full scale; reserved values stay as they are
            if (inc_q && cur_val < FULL) begin
              mem_q[ptr_q] <= cur_val + 9'h001;
            end
            if (nxt_q == ST_TX) begin
              sh_q <= rd_byte(cur_val, 1'b0);
              // High byte MSB is always zero, so the line goes low first
              sda_oe_o <= 1'b1;
              cnt_q <= 4'h0;
              state_q <= ST_TX;
            end else begin
              sda_oe_o <= 1'b0;
              state_q <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == `QP_LAST_TX_BIT) begin
              // Release so the master can answer
              sda_oe_o <= 1'b0;
              state_q <= ST_MACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_o <= ~sh_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s2_q;
          end else if (scl_fall) begin
            if (mack_q) begin
              // Same location again, alternating high and low byte
              lo_q <= ~lo_q;
              sh_q <= next_byte;
              sda_oe_o <= ~next_byte[7];
              cnt_q <= 4'h0;
              state_q <= ST_TX;
            end else begin
              sda_oe_o <= 1'b0;
              state_q <= ST_IGN;
            end
          end
        end
        ST_IGN: begin
          // Only a Start, or a Stop into idle, gets out of here
          sda_oe_o <= 1'b0;
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from the storage flops
  // ----------------------------------------------------------------
  // Wipers 3..0 and terminal control words 1..0
  assign wiper_o = {mem_q[`QP_ADDR_WIPER3], mem_q[`QP_ADDR_WIPER2],
                    mem_q[`QP_ADDR_WIPER1], mem_q[`QP_ADDR_WIPER0]};
  assign tcon_o = {mem_q[`QP_ADDR_TCON1], mem_q[`QP_ADDR_TCON0]};

endmodule // quad_pot_i2c_command_engine

/* File: quad_pot_assertions.sv */
// Port-level checker for the potentiometer command engine
`timescale 1ns/100ps
`include "quad_pot_regs.vh"
module quad_pot_checker #(
  parameter EIGHT_BIT = 1
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire brownout_reset_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire high_voltage_command_flag_o,
  input wire [35:0] wiper_o,
  input wire [17:0] tcon_o
);
  localparam [8:0] MID = EIGHT_BIT ? `QP_MID_8BIT : `QP_MID_7BIT;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || brownout_reset_i);
  // ----------------------------------------
  // Bus timing and state updates
  // ----------------------------------------
  sequence s_drive_hold;
    sda_oe_o [*4];
  endsequence
  property p_oe_on_low; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_oe_on_low: assert property (p_oe_on_low) else $error("sda drive moved with scl high");
  property p_oe_hold; $rose(sda_oe_o) |-> s_drive_hold; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda drive too short");
  // Bounded, since a stuck drive would hang the bus for good
  property p_oe_bound; sda_oe_o |-> ##[1:200] !sda_oe_o; endproperty
  a_oe_bound: assert property (p_oe_bound) else $error("sda never released");
  property p_sda_zero; sda_o == 1'b0; endproperty
  a_sda_zero: assert property (p_sda_zero) else $error("sda output not low");
  property p_flag_at_start; $changed(high_voltage_command_flag_o) |-> scl_i; endproperty
  a_flag_at_start: assert property (p_flag_at_start) else $error("flag moved off a start");
  property p_wiper_on_low; $changed(wiper_o) |-> !scl_i; endproperty
  a_wiper_on_low: assert property (p_wiper_on_low) else $error("wiper moved with scl high");
  property p_tcon_on_low; $changed(tcon_o) |-> !scl_i; endproperty
  a_tcon_on_low: assert property (p_tcon_on_low) else $error("tcon moved with scl high");
  property p_reset_vals; $fell(rst_i) |-> !sda_oe_o && wiper_o == {4{MID}} && tcon_o == {2{9'h1ff}}; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
endmodule // quad_pot_checker

/* File: i2c_master_model.sv */
// Behavioural I2C bus master facing the engine
`timescale 1ns/100ps
module i2c_master_model (
  input wire clk_i,
  input wire sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Idle bus: clock high, data left to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Eight clocks a level keep SCL well above the sampler's minimum
  task automatic hp;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic start;
    sda_oe_o = 1'b0;
    hp;
    scl_o = 1'b1;
    hp;
    sda_oe_o = 1'b1;
    hp;
    scl_o = 1'b0;
  endtask
  task automatic stop;
    sda_oe_o = 1'b1;
    hp;
    scl_o = 1'b1;
    hp;
    sda_oe_o = 1'b0;
    hp;
  endtask
  // Data set while SCL low, sampled at the end of SCL high
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = !b;
    hp;
    scl_o = 1'b1;
    hp;
    r = sda_i;
    scl_o = 1'b0;
  endtask
  // Byte plus ninth bit; ab=0 acks a read byte, 1 releases or ends it
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ab, r);
  endtask
endmodule // i2c_master_model

/* File: tb_top.sv */
// Self-checking bench for the quad potentiometer command engine
`timescale 1ns/100ps
`include "quad_pot_regs.vh"
module tb_top;
  localparam [4:0] AH = 5'h0a; // Arbitrary upper address bits
  localparam [4:0] AH7 = 5'h0b; // Arbitrary, differs from AH
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic bor = 1'b0;
  logic pin0 = 1'b0;
  logic pin1 = 1'b0;
  logic hv = 1'b0;
  wire scl;
  wire m_oe;
  wire d_oe;
  wire d7_oe;
  wire [35:0] wip7;
  wire hv_o;
  wire [35:0] wip;
  wire [17:0] tc;
  wire sda = !(m_oe || d_oe || d7_oe); // Open drain with pull-up
  int n_mismatch = 0;
  int checks_done = 0;
  logic [8:0] e [16];
  logic [7:0] q;
  logic r;
  logic [3:0] a4;
  logic [3:0] va [6] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'ha};
  always #4 sys_clk = !sys_clk;
  i2c_master_model m (.clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  quad_pot_i2c_command_engine #(.EIGHT_BIT(1), .SLAVE_ADDR_HI(AH)) dut_u (.sys_clk_i(sys_clk), .rst_i(rst),
    .brownout_reset_i(bor), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(d_oe),
    .slave_address_pin_zero_i(pin0), .slave_address_pin_one_i(pin1), .high_voltage_command_flag_i(hv),
    .high_voltage_command_flag_o(hv_o), .wiper_o(wip), .tcon_o(tc));
  // Second device on the same bus, built for the 7-bit resolution
  quad_pot_i2c_command_engine #(.EIGHT_BIT(0), .SLAVE_ADDR_HI(AH7)) dut7_u (.sys_clk_i(sys_clk), .rst_i(rst),
    .brownout_reset_i(bor), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(d7_oe),
    .slave_address_pin_zero_i(pin0), .slave_address_pin_one_i(pin1), .high_voltage_command_flag_i(hv),
    .high_voltage_command_flag_o(), .wiper_o(wip7), .tcon_o());
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [35:0] x, input logic [35:0] g);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  function automatic logic [8:0] inc(input logic [8:0] x);
    return (x < `QP_FULL_8BIT) ? x + 9'h001 : x;
  endfunction
  function automatic logic wp(input logic [3:0] a);
    return a == 4'h0 || a == 4'h1 || a == 4'h6 || a == 4'h7;
  endfunction
  task automatic rst_exp;
    foreach (va[i]) e[va[i]] = wp(va[i]) ? `QP_MID_8BIT : `QP_TCON_RESET;
  endtask
  task automatic cmpall;
    // Increments land a few clocks after the ack-ending SCL fall
    repeat (4) @(negedge sys_clk);
    chk("wipers", {e[7], e[6], e[1], e[0]}, wip);
    chk("tcon", {e[10], e[4]}, tc);
  endtask
  task automatic ctl(input logic rw);
    m.start();
    m.xfer({AH, pin1, pin0, rw}, 1'b1, q, r);
    chk("control ack", 36'h0, r);
  endtask
  // Command byte plus data byte for writes; ok tells whether an ack is due
  task automatic cw(input logic [3:0] a, input logic [1:0] op, input logic [8:0] d, input logic ok);
    m.xfer({a, op, 1'b0, d[8]}, 1'b1, q, r);
    chk("command ack", {35'h0, !ok}, r);
    if (ok && op == `QP_OP_WRITE) begin
      m.xfer(d[7:0], 1'b1, q, r);
      chk("data ack", 36'h0, r);
      e[a] = d;
    end
    if (ok && op == `QP_OP_INC)
      e[a] = inc(e[a]);
  endtask
  // Reads n words; set moves the pointer first, otherwise the kept pointer is used
  task automatic rd(input logic [3:0] a, input int n, input logic set);
    ctl(1'b0);
    if (set)
      cw(a, `QP_OP_READ, 9'h000, 1'b1);
    ctl(1'b1);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hff, 1'b0, q, r);
      chk("read high", {7'h0, e[a][8]}, q);
      m.xfer(8'hff, i == n - 1, q, r);
      chk("read low", e[a][7:0], q);
    end
    repeat (4) @(negedge sys_clk);
    chk("release", 36'h0, d_oe);
    m.stop();
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h5e77662b));
    pin0 = 1'($urandom);
    pin1 = 1'($urandom);
    rst_exp;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    cmpall;
    rd(4'h0, 1, 1'b0);
    ctl(1'b0);
    foreach (va[i]) cw(va[i], `QP_OP_WRITE, 9'($urandom), 1'b1);
    cmpall;
    repeat (16) begin
      a4 = va[$urandom % 6];
      cw(a4, wp(a4) && 1'($urandom) ? `QP_OP_INC : `QP_OP_WRITE, 9'($urandom), 1'b1);
      cmpall;
    end
    m.stop();
    foreach (va[i]) rd(va[i], 1 + i % 3, 1'b1);
    rd(4'ha, 1, 1'b0);
    ctl(1'b0);
    cw(4'h6, `QP_OP_WRITE, `QP_FULL_8BIT - 9'h001, 1'b1);
    cw(4'h6, `QP_OP_INC, 9'h000, 1'b1);
    cw(4'h6, `QP_OP_INC, 9'h000, 1'b1);
    cw(4'h7, `QP_OP_WRITE, 9'h1ff, 1'b1);
    cw(4'h7, `QP_OP_INC, 9'h000, 1'b1);
    cw(4'h0, `QP_OP_WRITE, 9'h000, 1'b1);
    cw(4'h0, `QP_OP_INC, 9'h000, 1'b1);
    cw(4'h1, `QP_OP_WRITE, 9'h0a5, 1'b1);
    m.stop();
    cmpall;
    for (int k = 0; k < 3; k++) begin
      ctl(1'b0);
      cw(k == 0 ? 4'h4 : k == 1 ? 4'h3 : 4'h0, k == 2 ? `QP_OP_DEC : `QP_OP_INC, 9'h000, 1'b0);
      cw(4'h0, `QP_OP_WRITE, 9'h000, 1'b0);
      m.stop();
    end
    cmpall;
    ctl(1'b0);
    m.xfer({4'h1, `QP_OP_WRITE, 2'b01}, 1'b1, q, r);
    for (int k = 0; k < 5; k++) m.bit_io(1'b0, r);
    m.stop();
    cmpall;
    hv = 1'b1;
    m.hp();
    ctl(1'b0);
    chk("hv flag", 36'h1, hv_o);
    m.stop();
    hv = 1'b0;
    ctl(1'b0);
    chk("hv flag", 36'h0, hv_o);
    m.stop();
    // 7-bit part: increment stops at its own full scale
    m.start();
    m.xfer({AH7, pin1, pin0, 1'b0}, 1'b1, q, r);
    chk("control ack 7-bit", 36'h0, r);
    m.xfer({4'h1, `QP_OP_WRITE, 2'b00}, 1'b1, q, r);
    m.xfer(8'h7f, 1'b1, q, r);
    repeat (2) m.xfer({4'h1, `QP_OP_INC, 2'b00}, 1'b1, q, r);
    chk("inc ack 7-bit", 36'h0, r);
    m.stop();
    repeat (4) @(negedge sys_clk);
    chk("wipers 7-bit", {`QP_MID_7BIT, `QP_MID_7BIT, `QP_FULL_7BIT, `QP_MID_7BIT}, wip7);
    cmpall;
    bor = 1'b1;
    repeat (4) @(negedge sys_clk);
    bor = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_exp;
    cmpall;
    rd(4'h0, 1, 1'b0);
    tally_and_finish;
  end
  // Watchdog sized well beyond the expected run
  initial begin
    #800000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule // tb_top
bind quad_pot_i2c_command_engine quad_pot_checker #(.EIGHT_BIT(EIGHT_BIT)) chk_u (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .brownout_reset_i(brownout_reset_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .high_voltage_command_flag_o(high_voltage_command_flag_o), .wiper_o(wiper_o), .tcon_o(tcon_o));
